// file: rtl/led_defs.svh
// Named constants for the status indicator driver
`ifndef LED_DEFS_SVH
`define LED_DEFS_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define LED_ADDR_W          8
`define LED_DATA_W          32
`define LED_REG_CTRL        8'h00
`define LED_REG_STATUS      8'h04
`define LED_CTRL_RESET      32'h0000_0000
`define LED_CTRL_MODE3_BIT  0
`define LED_CTRL_DUPLEX_LSB 1
`define LED_ST_STRAP_BIT    0
`define LED_ST_MODE3_BIT    1
`define LED_ST_POL_LSB      8
`define LED_ST_LIT_LSB      16

// ----------------------------------------------------------------
// Pin layout: three indicators per port
// ----------------------------------------------------------------
`define LED_PORTS           2
`define LED_PINS_PER_PORT   3
`define LED_PIN_COUNT       6
`define LED_PIN_LINK        0
`define LED_PIN_RATE        1
`define LED_PIN_THIRD       2

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define LED_CLK_PERIOD_NS   10
`define LED_RESET_MIN_NS    1000
`define LED_BLINK_HALF_MS   50
`define LED_NS_PER_MS       1000000

`endif

// file: rtl/led_pkg.sv
// Types shared by the status indicator driver
package led_pkg;

   // Display mode of the indicator set
   typedef enum logic [1:0] {
      MODE_STRAP_ONE,
      MODE_STRAP_TWO,
      MODE_REG_THREE
   } display_mode_t;

endpackage

// file: rtl/led_chan_if.sv
// Per-port status and indicator levels between top and channel
`timescale 1ns/1ps
interface led_chan_if import led_pkg::*; ();
   logic          link_good;
   logic          speed_100;
   logic          tx_active;
   logic          rx_active;
   logic          collision;
   logic          full_duplex;
   display_mode_t mode;
   logic          duplex_sel;
   logic          blink_phase;
   logic [2:0]    lit;

   modport ctrl (output link_good, speed_100, tx_active, rx_active,
                 collision, full_duplex, mode, duplex_sel, blink_phase,
                 input lit);
   modport chan (input link_good, speed_100, tx_active, rx_active,
                 collision, full_duplex, mode, duplex_sel, blink_phase,
                 output lit);
endinterface

// file: rtl/blink_timer.sv
// Free-running divider giving the activity blink phase
`timescale 1ns/1ps
module blink_timer #(
   parameter int unsigned HALF_CYCLES = 5000000
) (
   input  wire logic core_clk_in,
   input  wire logic rst_n_in,
   output wire logic blink_phase_out
);

   localparam logic [31:0] LAST_COUNT = 32'(HALF_CYCLES - 1);

   logic [31:0] count_reg;
   logic [31:0] count_next;
   logic        phase_reg;
   logic        phase_next;
   wire         wrap_w = (count_reg >= LAST_COUNT);

   // ----------------------------------------------------------------
   // Divider
   // ----------------------------------------------------------------
   // fixed blink half period
   assign count_next = wrap_w ? 32'h0000_0000 : count_reg + 32'h0000_0001;
   assign phase_next = wrap_w ? ~phase_reg : phase_reg;

   // Counter and phase flops
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         count_reg <= 32'h0000_0000;
         phase_reg <= 1'b0;
      end else begin
         count_reg <= count_next;
         phase_reg <= phase_next;
      end
   end

   assign blink_phase_out = phase_reg;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   // toggles on wrap only
   blink_wrap_a: assert property (@(posedge core_clk_in)
      disable iff (!rst_n_in)
      $changed(phase_reg) |-> $past(count_reg) == LAST_COUNT)
      else $error("blink phase toggled off the period boundary");
endmodule

// file: rtl/led_port_channel.sv
// Indicator decode for one port
`timescale 1ns/1ps
`include "led_defs.svh"
module led_port_channel import led_pkg::*; (
   input  wire logic core_clk_in,
   input  wire logic rst_n_in,
   led_chan_if.chan  ch
);

   wire traffic_w   = ch.tx_active | ch.rx_active;
   wire blink_off_w = traffic_w & ~ch.blink_phase;
   wire mode_one_w  = (ch.mode == MODE_STRAP_ONE);
   wire mode_three_w = (ch.mode == MODE_REG_THREE);

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   // link steady or link with blink
   assign ch.lit[`LED_PIN_LINK] = mode_one_w ? ch.link_good
                                             : ch.link_good & ~blink_off_w;
   assign ch.lit[`LED_PIN_RATE] = ch.speed_100;
   assign ch.lit[`LED_PIN_THIRD] =
      mode_one_w ? traffic_w :
      (mode_three_w && ch.duplex_sel) ? ch.full_duplex : ch.collision;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   sequence active_link_s;
      ch.link_good && traffic_w && !mode_one_w;
   endsequence

   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (!rst_n_in);

   link_steady_a: assert property (
      mode_one_w |-> ch.lit[`LED_PIN_LINK] == ch.link_good)
      else $error("mode 1 link indicator differs from link");
   link_blink_a: assert property (
      active_link_s |-> ch.lit[`LED_PIN_LINK] == ch.blink_phase)
      else $error("link indicator does not blink with activity");
   rate_follow_a: assert property (
      ch.lit[`LED_PIN_RATE] == ch.speed_100)
      else $error("rate indicator differs from speed");
   act_show_a: assert property (
      mode_one_w |-> ch.lit[`LED_PIN_THIRD] == traffic_w)
      else $error("mode 1 third indicator differs from activity");
   coll_show_a: assert property (
      ch.mode == MODE_STRAP_TWO
      |-> ch.lit[`LED_PIN_THIRD] == ch.collision)
      else $error("mode 2 third indicator differs from collision");
   duplex_show_a: assert property (
      mode_three_w && ch.duplex_sel
      |-> ch.lit[`LED_PIN_THIRD] == ch.full_duplex)
      else $error("mode 3 third indicator differs from duplex");
endmodule

// file: rtl/phy_status_led_driver.sv
// Dual-port status indicator driver with strap capture and registers
`timescale 1ns/1ps
`include "led_defs.svh"
module phy_status_led_driver import led_pkg::*; #(
   parameter int unsigned BLINK_HALF_CYCLES =
      `LED_BLINK_HALF_MS * (`LED_NS_PER_MS / `LED_CLK_PERIOD_NS)
) (
   input  wire logic                   core_clk_in,
   input  wire logic                   rst_n_in,
   // Register port
   input  wire logic [`LED_ADDR_W-1:0] reg_addr_in,
   input  wire logic [`LED_DATA_W-1:0] reg_wdata_in,
   input  wire logic                   reg_wr_in,
   input  wire logic                   reg_rd_in,
   output wire logic [`LED_DATA_W-1:0] reg_rdata_out,
   // Strap for display mode, high selects mode 1
   input  wire logic                   mode_strap_in,
   // Per-port status, bit 0 is port 0
   input  wire logic [1:0]             link_good_in,
   input  wire logic [1:0]             speed_100_in,
   input  wire logic [1:0]             tx_active_in,
   input  wire logic [1:0]             rx_active_in,
   input  wire logic [1:0]             collision_in,
   input  wire logic [1:0]             full_duplex_in,
   // Indicator pins, port 0
   input  wire logic                   link_indicator_port0_in,
   output wire logic                   link_indicator_port0_out,
   output wire logic                   link_indicator_port0_oe_out,
   input  wire logic                   rate_indicator_port0_in,
   output wire logic                   rate_indicator_port0_out,
   output wire logic                   rate_indicator_port0_oe_out,
   input  wire logic                   traffic_or_collision_indicator_port0_in,
   output wire logic                   traffic_or_collision_indicator_port0_out,
   output wire logic                   traffic_or_collision_indicator_port0_oe_out,
   // Indicator pins, port 1
   input  wire logic                   link_indicator_port1_in,
   output wire logic                   link_indicator_port1_out,
   output wire logic                   link_indicator_port1_oe_out,
   input  wire logic                   rate_indicator_port1_in,
   output wire logic                   rate_indicator_port1_out,
   output wire logic                   rate_indicator_port1_oe_out,
   input  wire logic                   traffic_or_collision_indicator_port1_in,
   output wire logic                   traffic_or_collision_indicator_port1_out,
   output wire logic                   traffic_or_collision_indicator_port1_oe_out
);

   // Shortest reset pulse the board must give, in cycles
   localparam int unsigned RESET_MIN_CYCLES =
      (`LED_RESET_MIN_NS + `LED_CLK_PERIOD_NS - 1) / `LED_CLK_PERIOD_NS;

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic [`LED_DATA_W-1:0]    ctrl_reg;
   logic [`LED_DATA_W-1:0]    ctrl_next;
   logic [`LED_DATA_W-1:0]    rdata_reg;
   logic [`LED_DATA_W-1:0]    rdata_next;
   logic                      strap_mode_reg;
   logic [`LED_PIN_COUNT-1:0] pol_reg;
   logic [`LED_PIN_COUNT-1:0] out_reg;
   logic [`LED_PIN_COUNT-1:0] out_next;
   logic                      oe_reg;
   logic [`LED_PIN_COUNT-1:0] pin_in_w;
   logic [`LED_PIN_COUNT-1:0] lit_w;
   logic                      blink_w;
   display_mode_t             mode_w;
   logic [RESET_MIN_CYCLES-1:0] reset_hist_reg;

   led_chan_if ch [`LED_PORTS] ();

   // ----------------------------------------------------------------
   // Pin gathering
   // ----------------------------------------------------------------
   // Pin levels, three per port, port 0 low
   assign pin_in_w = {traffic_or_collision_indicator_port1_in,
                      rate_indicator_port1_in,
                      link_indicator_port1_in,
                      traffic_or_collision_indicator_port0_in,
                      rate_indicator_port0_in,
                      link_indicator_port0_in};

   // ----------------------------------------------------------------
   // Register port
   // ----------------------------------------------------------------
   wire ctrl_hit_w   = (reg_addr_in == `LED_REG_CTRL);
   wire status_hit_w = (reg_addr_in == `LED_REG_STATUS);
   wire mode3_w      = ctrl_reg[`LED_CTRL_MODE3_BIT];

   // Status word: strap, mode, polarity and live indicator levels
   wire [`LED_DATA_W-1:0] status_w =
      (`LED_DATA_W'(strap_mode_reg) << `LED_ST_STRAP_BIT) |
      (`LED_DATA_W'(mode3_w)        << `LED_ST_MODE3_BIT) |
      (`LED_DATA_W'(pol_reg)        << `LED_ST_POL_LSB)   |
      (`LED_DATA_W'(lit_w)          << `LED_ST_LIT_LSB);

   // Only the mode and duplex select bits are writable
   wire [`LED_DATA_W-1:0] ctrl_mask_w =
      (`LED_DATA_W'(1) << `LED_CTRL_MODE3_BIT) |
      (`LED_DATA_W'(3) << `LED_CTRL_DUPLEX_LSB);

   assign ctrl_next = (reg_wr_in && ctrl_hit_w) ?
                      (reg_wdata_in & ctrl_mask_w) : ctrl_reg;

   // Read mux, unmapped addresses read zero
   assign rdata_next = !reg_rd_in   ? `LED_DATA_W'(0) :
                       ctrl_hit_w   ? ctrl_reg :
                       status_hit_w ? status_w : `LED_DATA_W'(0);

   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         ctrl_reg  <= `LED_CTRL_RESET;
         rdata_reg <= `LED_DATA_W'(0);
      end else begin
         ctrl_reg  <= ctrl_next;
         rdata_reg <= rdata_next;
      end
   end

   assign reg_rdata_out = rdata_reg;

   // ----------------------------------------------------------------
   // Strap capture
   // ----------------------------------------------------------------
   // straps re-sampled every reset cycle
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         strap_mode_reg <= mode_strap_in;
         pol_reg        <= pin_in_w;
      end
   end

   // Reset history for the pulse-length check
   always_ff @(posedge core_clk_in) begin
      reset_hist_reg <= {reset_hist_reg[RESET_MIN_CYCLES-2:0], rst_n_in};
   end

   // ----------------------------------------------------------------
   // Mode selection and channels
   // ----------------------------------------------------------------
   // register mode overrides the strapped mode
   assign mode_w = mode3_w        ? MODE_REG_THREE :
                   strap_mode_reg ? MODE_STRAP_ONE : MODE_STRAP_TWO;

   blink_timer #(
      .HALF_CYCLES (BLINK_HALF_CYCLES)
   ) u_blink (
      .core_clk_in     (core_clk_in),
      .rst_n_in        (rst_n_in),
      .blink_phase_out (blink_w)
   );

   // One decoder per port
   for (genvar p = 0; p < `LED_PORTS; p++) begin : g_port
      assign ch[p].link_good   = link_good_in[p];
      assign ch[p].speed_100   = speed_100_in[p];
      assign ch[p].tx_active   = tx_active_in[p];
      assign ch[p].rx_active   = rx_active_in[p];
      assign ch[p].collision   = collision_in[p];
      assign ch[p].full_duplex = full_duplex_in[p];
      assign ch[p].mode        = mode_w;
      assign ch[p].duplex_sel  = ctrl_reg[`LED_CTRL_DUPLEX_LSB + p];
      assign ch[p].blink_phase = blink_w;
      assign lit_w[p*`LED_PINS_PER_PORT +: `LED_PINS_PER_PORT] = ch[p].lit;

      led_port_channel u_chan (
         .core_clk_in (core_clk_in),
         .rst_n_in    (rst_n_in),
         .ch          (ch[p])
      );
   end

   // ----------------------------------------------------------------
   // Pin drive
   // ----------------------------------------------------------------
   // pulled-up pins drive active low
   assign out_next = lit_w ^ pol_reg;

   // Output flops, pins released while in reset for strap sampling
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         out_reg <= `LED_PIN_COUNT'(0);
         oe_reg  <= 1'b0;
      end else begin
         out_reg <= out_next;
         oe_reg  <= 1'b1;
      end
   end

   assign link_indicator_port0_out =
      out_reg[`LED_PIN_LINK];
   assign rate_indicator_port0_out =
      out_reg[`LED_PIN_RATE];
   assign traffic_or_collision_indicator_port0_out =
      out_reg[`LED_PIN_THIRD];
   assign link_indicator_port1_out =
      out_reg[`LED_PINS_PER_PORT + `LED_PIN_LINK];
   assign rate_indicator_port1_out =
      out_reg[`LED_PINS_PER_PORT + `LED_PIN_RATE];
   assign traffic_or_collision_indicator_port1_out =
      out_reg[`LED_PINS_PER_PORT + `LED_PIN_THIRD];

   assign link_indicator_port0_oe_out                 = oe_reg;
   assign rate_indicator_port0_oe_out                 = oe_reg;
   assign traffic_or_collision_indicator_port0_oe_out = oe_reg;
   assign link_indicator_port1_oe_out                 = oe_reg;
   assign rate_indicator_port1_oe_out                 = oe_reg;
   assign traffic_or_collision_indicator_port1_oe_out = oe_reg;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   sequence in_reset_s;
      !rst_n_in;
   endsequence

   sequence running_s;
      rst_n_in && $past(rst_n_in);
   endsequence

   // Port 1 pin positions in the six-pin vector
   localparam int LINK1_IDX  = `LED_PINS_PER_PORT + `LED_PIN_LINK;
   localparam int RATE1_IDX  = `LED_PINS_PER_PORT + `LED_PIN_RATE;
   localparam int THIRD1_IDX = `LED_PINS_PER_PORT + `LED_PIN_THIRD;

   mode_pick_a: assert property (@(posedge core_clk_in)
      rst_n_in && mode3_w |-> mode_w == MODE_REG_THREE)
      else $error("register mode not selected");
   strap_pick_a: assert property (@(posedge core_clk_in)
      rst_n_in && !mode3_w |-> mode_w != MODE_REG_THREE
         && (mode_w == MODE_STRAP_ONE) == strap_mode_reg)
      else $error("strapped mode not selected");
   pin_drive_a: assert property (@(posedge core_clk_in)
      running_s |-> oe_reg)
      else $error("indicator pins not driven after reset");
   pol_apply_a: assert property (@(posedge core_clk_in)
      running_s |-> out_reg == ($past(lit_w) ^ pol_reg))
      else $error("indicator level ignores strapped polarity");
   link_pin_a: assert property (@(posedge core_clk_in)
      running_s ##0 ($past(mode_w) == MODE_STRAP_ONE)
      |-> out_reg[LINK1_IDX] ==
          ($past(link_good_in[1]) ^ pol_reg[LINK1_IDX]))
      else $error("port 1 link pin wrong in mode 1");
   rate_pin_a: assert property (@(posedge core_clk_in)
      running_s |-> out_reg[`LED_PIN_RATE] ==
         ($past(speed_100_in[0]) ^ pol_reg[`LED_PIN_RATE]))
      else $error("port 0 rate pin wrong");
   rate_pin1_a: assert property (@(posedge core_clk_in)
      running_s |-> out_reg[RATE1_IDX] ==
         ($past(speed_100_in[1]) ^ pol_reg[RATE1_IDX]))
      else $error("port 1 rate pin wrong");
   act_pin_a: assert property (@(posedge core_clk_in)
      running_s ##0 ($past(mode_w) == MODE_STRAP_ONE)
      |-> out_reg[THIRD1_IDX] == (pol_reg[THIRD1_IDX]
          ^ ($past(tx_active_in[1]) | $past(rx_active_in[1]))))
      else $error("port 1 activity pin wrong in mode 1");
   coll_pin_a: assert property (@(posedge core_clk_in)
      running_s ##0 ($past(mode_w) == MODE_STRAP_TWO)
      |-> out_reg[`LED_PIN_THIRD] ==
          ($past(collision_in[0]) ^ pol_reg[`LED_PIN_THIRD]))
      else $error("port 0 collision pin wrong in mode 2");
   ctrl_write_a: assert property (@(posedge core_clk_in)
      disable iff (!rst_n_in)
      reg_wr_in && ctrl_hit_w
      |=> ctrl_reg == ($past(reg_wdata_in) & ctrl_mask_w))
      else $error("control write not applied");
   ctrl_keep_a: assert property (@(posedge core_clk_in)
      disable iff (!rst_n_in)
      !(reg_wr_in && ctrl_hit_w) |=> $stable(ctrl_reg))
      else $error("control changed without a write");
   reset_default_a: assert property (@(posedge core_clk_in)
      in_reset_s |=> ctrl_reg == `LED_CTRL_RESET && !oe_reg)
      else $error("reset left register or drive active");
   reset_pulse_a: assert property (@(posedge core_clk_in)
      $rose(rst_n_in) && reset_hist_reg[RESET_MIN_CYCLES-1:1] == '0
      |-> ctrl_reg == `LED_CTRL_RESET && pol_reg == $past(pin_in_w))
      else $error("full reset pulse did not restore defaults");
   strap_take_a: assert property (@(posedge core_clk_in)
      in_reset_s |=> strap_mode_reg == $past(mode_strap_in)
                     && pol_reg == $past(pin_in_w))
      else $error("strap not re-sampled in reset");
   strap_hold_a: assert property (@(posedge core_clk_in)
      running_s |-> $stable(strap_mode_reg) && $stable(pol_reg))
      else $error("strap value changed outside reset");
   read_late_a: assert property (@(posedge core_clk_in)
      disable iff (!rst_n_in)
      reg_rd_in && status_hit_w |=> reg_rdata_out == $past(status_w))
      else $error("status read data wrong");
   read_ctrl_a: assert property (@(posedge core_clk_in)
      disable iff (!rst_n_in)
      reg_rd_in && ctrl_hit_w |=> reg_rdata_out == $past(ctrl_reg))
      else $error("control read data wrong");
   read_idle_a: assert property (@(posedge core_clk_in)
      disable iff (!rst_n_in)
      !reg_rd_in |=> reg_rdata_out == `LED_DATA_W'(0))
      else $error("read data not cleared after one cycle");
endmodule

// file: test/led_board_model.sv
// Board model: strap resistors and indicator lamps on the six pins
`timescale 1ns/1ps
module led_board_model (
   input  wire logic [5:0] strap_lvl_in,
   input  wire logic [5:0] drive_in,
   input  wire logic [5:0] oe_in,
   output wire logic [5:0] pin_out,
   output wire logic [5:0] lamp_out
);
   // ----------------------------------------------------------------
   // Pin level and lamp state
   // ----------------------------------------------------------------
   // resistor sets level: an undriven pin sits at its strap
   assign pin_out  = (oe_in & drive_in) | (~oe_in & strap_lvl_in);
   // lamp polarity: lit when driven away from the pull level
   assign lamp_out = oe_in & (drive_in ^ strap_lvl_in);
endmodule

// file: test/tb_top.sv
// Self-checking bench for the status indicator driver
`timescale 1ns/1ps
`include "led_defs.svh"
module tb_top;
   logic        core_clk_in = 1'b0;
   logic        rst_n_in, wr, rd, mode_strap, lamp_req;
   logic        rd_d = 1'b0;
   logic [7:0]  addr;
   logic [31:0] wdata, seed;
   logic [11:0] st;
   logic [5:0]  strap_lvl;
   logic [2:0]  ctrl;
   wire  [31:0] rdata;
   wire  [5:0]  drive, oe, pin, lamp;
   int          n_mismatch, check_count, cycles, cnt;
   logic [31:0] rd_q[$];
   logic [5:0]  lamp_q[$];

   phy_status_led_driver #(.BLINK_HALF_CYCLES(4)) phy_status_led_driver_inst (
      .core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
      .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
      .reg_rd_in(rd), .reg_rdata_out(rdata), .mode_strap_in(mode_strap),
      .link_good_in(st[1:0]), .speed_100_in(st[3:2]),
      .tx_active_in(st[5:4]), .rx_active_in(st[7:6]),
      .collision_in(st[9:8]), .full_duplex_in(st[11:10]),
      .link_indicator_port0_in(pin[0]), .link_indicator_port0_out(drive[0]),
      .link_indicator_port0_oe_out(oe[0]),
      .rate_indicator_port0_in(pin[1]), .rate_indicator_port0_out(drive[1]),
      .rate_indicator_port0_oe_out(oe[1]),
      .traffic_or_collision_indicator_port0_in(pin[2]),
      .traffic_or_collision_indicator_port0_out(drive[2]),
      .traffic_or_collision_indicator_port0_oe_out(oe[2]),
      .link_indicator_port1_in(pin[3]), .link_indicator_port1_out(drive[3]),
      .link_indicator_port1_oe_out(oe[3]),
      .rate_indicator_port1_in(pin[4]), .rate_indicator_port1_out(drive[4]),
      .rate_indicator_port1_oe_out(oe[4]),
      .traffic_or_collision_indicator_port1_in(pin[5]),
      .traffic_or_collision_indicator_port1_out(drive[5]),
      .traffic_or_collision_indicator_port1_oe_out(oe[5]));

   led_board_model led_board_model_inst (
      .strap_lvl_in(strap_lvl), .drive_in(drive), .oe_in(oe),
      .pin_out(pin), .lamp_out(lamp));

   // ----------------------------------------------------------------
   // Clock, helpers and expectations
   // ----------------------------------------------------------------
   always #5 core_clk_in = ~core_clk_in;

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // Lit pattern, index 3*port+k; no activity in modes 2 and 3
   function automatic logic [5:0] exp_lit(input logic [11:0] v);
      logic       m1;
      logic [5:0] r;
      m1 = mode_strap & ~ctrl[0];
      for (int p = 0; p < 2; p++) begin
         r[3*p]   = v[p];
         r[3*p+1] = v[2+p];
         r[3*p+2] = m1 ? (v[4+p] | v[6+p]) :
                    ((ctrl[0] & ctrl[1+p]) ? v[10+p] : v[8+p]);
      end
      return r;
   endfunction

   function automatic logic [31:0] exp_status();
      return {10'h000, exp_lit(st), 2'h0, strap_lvl, 6'h00, ctrl[0],
              mode_strap};
   endfunction

   task automatic tick(input int n);
      repeat (n) @(posedge core_clk_in);
   endtask

   task automatic cmp_word(input string what, input logic [31:0] e,
                           input logic [31:0] s);
      check_count++;
      if (s !== e) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", what, e, s);
      end
   endtask

   task automatic cmp_lamp(input logic [5:0] e, input logic [5:0] s);
      check_count++;
      if (s !== e) begin
         n_mismatch++;
         $display("Error lamps expected %b seen %b", e, s);
      end
   endtask

   // Strapped reset; lamps must be dark while it is held
   task automatic do_reset(input int n, input logic ms, input logic [5:0] sl);
      mode_strap <= ms;
      strap_lvl  <= sl;
      rst_n_in   <= 1'b0;
      // No traffic, so status reads after reset never see a blink
      st         <= st & 12'hF0F;
      ctrl = 3'h0;
      tick(n - 1);
      lamp_q.push_back(6'h00);
      lamp_req <= 1'b1;
      tick(1);
      lamp_req <= 1'b0;
      rst_n_in <= 1'b1;
      tick(1);
   endtask

   task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      tick(1);
      wr    <= 1'b0;
      tick(1);
   endtask

   task automatic reg_read(input logic [7:0] a, input logic [31:0] e);
      rd_q.push_back(e);
      addr <= a;
      rd   <= 1'b1;
      tick(1);
      rd   <= 1'b0;
      tick(1);
   endtask

   task automatic set_status(input logic [11:0] v);
      st <= v;
      tick(2);
      lamp_q.push_back(exp_lit(v));
      lamp_req <= 1'b1;
      tick(1);
      lamp_req <= 1'b0;
   endtask

   task automatic results();
      $display("Checks %0d, mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Result monitor and hang limit
   // ----------------------------------------------------------------
   always @(posedge core_clk_in) begin
      cycles++;
      if (rd_d)
         cmp_word("reg_rdata_out", rd_q.pop_front(), rdata);
      if (lamp_req)
         cmp_lamp(lamp_q.pop_front(), lamp);
      rd_d <= rd;
      if (cycles == 20000) begin
         n_mismatch++;
         results();
      end
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      {wr, rd, lamp_req} = 3'h0;
      addr = 8'h00;
      wdata = 32'h0000_0000;
      st = 12'h000;
      seed = 32'h0001_5EAB;
      n_mismatch = 0;
      check_count = 0;
      do_reset(8, 1'b1, 6'h16);
      reg_read(`LED_REG_CTRL, 32'h0000_0000);
      set_status(12'h0C5);
      reg_read(`LED_REG_STATUS, exp_status());
      reg_write(8'h08, 32'hFFFF_FFFF);
      reg_read(8'h08, 32'h0000_0000);
      reg_read(`LED_REG_CTRL, 32'h0000_0000);
      repeat (24) begin
         seed = lfsr(seed);
         set_status(seed[11:0]);
      end
      do_reset(100, 1'b0, 6'h29);
      reg_read(`LED_REG_STATUS, exp_status());
      repeat (24) begin
         seed = lfsr(seed);
         set_status(seed[11:0] & 12'hF0F);
      end
      st <= 12'h013;
      tick(3);
      cnt = 0;
      repeat (8) begin
         tick(1);
         #1;
         cnt += (lamp[0] === 1'b1);
      end
      cmp_word("blink_on_cycles", 32'h4, cnt);
      for (int i = 1; i < 8; i += 2) begin
         reg_write(`LED_REG_CTRL, {29'h1FFF_FFFF, i[2:0]});
         ctrl = i[2:0];
         reg_read(`LED_REG_CTRL, {29'h0, i[2:0]});
         repeat (6) begin
            seed = lfsr(seed);
            set_status(seed[11:0] & 12'hF0F);
         end
         reg_read(`LED_REG_STATUS, exp_status());
      end
      do_reset(100, 1'b1, 6'h0F);
      reg_read(`LED_REG_CTRL, 32'h0000_0000);
      set_status(12'h0F3);
      // Let the monitor take the last compare before the verdict
      tick(1);
      results();
   end
endmodule
